// >>> tcc_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"
module tcc_capture import tcc_pkg::*; #(
  parameter int NC_SAMPLES = `TCC_NC_SAMPLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic cmp_i,
  input  wire logic cmp_sel_i,
  input  wire logic nc_en_i,
  input  wire logic edge_sel_i,
  input  wire logic enable_i,
  output var  logic event_o
);

  logic [1:0]            raw;
  logic [1:0]            sync1_reg;
  logic [1:0]            sync2_reg;
  logic                  sel_level;
  logic [NC_SAMPLES-2:0] hist_reg;
  logic [NC_SAMPLES-1:0] window;
  logic                  filt_reg;
  logic                  level;
  logic                  prev_reg;

  assign raw = {cmp_i, pin_i};

  // each trigger input has its own two-stage synchroniser
  for (genvar g = 0; g < `TCC_SYNC_STAGES; g++) begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
      end else begin
        sync1_reg[g] <= raw[g];
        sync2_reg[g] <= sync1_reg[g];
      end
    end
  end

  // a source switch can look like an edge; software clears the flag after
  assign sel_level = cmp_sel_i ? sync2_reg[1] : sync2_reg[0];

  // runs on the undivided clock, so prescaler settings never reach it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hist_reg <= '0;
    end else begin
      hist_reg <= {hist_reg[NC_SAMPLES-3:0], sel_level};
    end
  end

  // the live sample is the fourth, which keeps the added delay at four
  assign window = {hist_reg, sel_level};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_reg <= 1'b0;
    end else if (&window) begin
      filt_reg <= 1'b1;
    end else if (~|window) begin
      filt_reg <= 1'b0;
    end
  end

  assign level = nc_en_i ? filt_reg : sel_level;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level;
    end
  end

  // prev keeps tracking while disabled so re-enabling does not fire
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_o <= 1'b0;
    end else begin
      event_o <= enable_i & (edge_sel_i ? (level & ~prev_reg)
                                        : (~level & prev_reg));
    end
  end

endmodule
`default_nettype wire

// >>> tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// register byte offsets on the bus
`define TCC_OFS_CTRL_A  8'h00
`define TCC_OFS_CTRL_B  8'h04
`define TCC_OFS_CNT_LO  8'h08
`define TCC_OFS_CNT_HI  8'h0c
`define TCC_OFS_CAP_LO  8'h10
`define TCC_OFS_CAP_HI  8'h14
`define TCC_OFS_FLAGS   8'h18
`define TCC_OFS_IRQ_EN  8'h1c
`define TCC_OFS_CMP_CS  8'h20

// field positions
`define TCC_A_WGM_LSB   0
`define TCC_B_CS_LSB    0
`define TCC_B_WGM_LSB   3
`define TCC_B_CES_BIT   6
`define TCC_B_NC_BIT    7
`define TCC_FLAG_OVF    0
`define TCC_FLAG_CAP    1
`define TCC_CMP_CAPSEL  2

// reset values
`define TCC_CTRL_RST    8'h00
`define TCC_CNT_RST     16'h0000
`define TCC_BYTE_RST    8'h00

// clock select codes
`define TCC_CS_STOP     3'h0
`define TCC_CS_DIV1     3'h1
`define TCC_CS_DIV8     3'h2
`define TCC_CS_DIV64    3'h3
`define TCC_CS_DIV256   3'h4
`define TCC_CS_DIV1024  3'h5
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7

// prescaler tap masks
`define TCC_PRE_M8      10'h007
`define TCC_PRE_M64     10'h03f
`define TCC_PRE_M256    10'h0ff
`define TCC_PRE_M1024   10'h3ff

// count limits
`define TCC_MAX         16'hffff
`define TCC_BOTTOM      16'h0000
`define TCC_TOP8        16'h00ff
`define TCC_TOP9        16'h01ff
`define TCC_TOP10       16'h03ff

// waveform modes
`define TCC_WGM_NORMAL  4'h0
`define TCC_WGM_PC8     4'h1
`define TCC_WGM_PC9     4'h2
`define TCC_WGM_PC10    4'h3
`define TCC_WGM_CTC_OCR 4'h4
`define TCC_WGM_FAST8   4'h5
`define TCC_WGM_FAST9   4'h6
`define TCC_WGM_FAST10  4'h7
`define TCC_WGM_PFC_ICR 4'h8
`define TCC_WGM_PFC_OCR 4'h9
`define TCC_WGM_PC_ICR  4'ha
`define TCC_WGM_PC_OCR  4'hb
`define TCC_WGM_CTC_ICR 4'hc
`define TCC_WGM_FST_ICR 4'he
`define TCC_WGM_FST_OCR 4'hf

`define TCC_NC_SAMPLES  4
`define TCC_SYNC_STAGES 2

`endif

// >>> tcc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output var  logic        hsel_o,
  output var  logic [31:0] haddr_o,
  output var  logic [1:0]  htrans_o,
  output var  logic        hwrite_o,
  output var  logic [2:0]  hsize_o,
  output var  logic [31:0] hwdata_o,
  output var  logic [7:0]  rdata_o,
  output var  logic        rdone_o
);
  initial begin
    hsel_o = 1'b1;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
    rdata_o = 8'h00;
    rdone_o = 1'b0;
  end
  // released lines are scrambled so a stale value never looks valid
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk_i);
    htrans_o <= 2'h2;
    haddr_o <= {24'h0, a};
    hwrite_o <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= {24'h0, d};
    do @(posedge clk_i); while (hready_i !== 1'b1);
    haddr_o <= ~{24'h0, a};
    hwdata_o <= ~{24'h0, d};
    if (!w) begin
      rdata_o <= hrdata_i[7:0];
      rdone_o <= ~rdone_o;
    end
  endtask
  task automatic put16(input logic [7:0] lo, input logic [15:0] v);
    xfer(1'b1, lo + 8'h04, v[15:8]);
    xfer(1'b1, lo, v[7:0]);
  endtask
  task automatic get16(input logic [7:0] lo);
    xfer(1'b0, lo, 8'h00);
    xfer(1'b0, lo + 8'h04, 8'h00);
  endtask
endmodule
`default_nettype wire

// >>> tcc_pkg.sv
`default_nettype none
package tcc_pkg;

  typedef enum logic {
    SLOPE_UP,
    SLOPE_DOWN
  } tcc_slope_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } tcc_req_type;

  typedef struct packed {
    logic [15:0] top;
    logic        dual;
    logic        fast;
    logic        icr_top;
  } tcc_mode_type;

endpackage
`default_nettype wire

// >>> tcc_timer16.sv
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"
module tcc_timer16 import tcc_pkg::*; (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output var  logic [31:0] HRDATA_O,
  output var  logic        HREADYOUT_O,
  output var  logic        HRESP_O,
  input  wire logic        EXT_COUNT_PIN_I,
  input  wire logic        CAPTURE_PIN_I,
  input  wire logic        COMPARATOR_OUTPUT_I,
  input  wire logic        OVF_ACK_I,
  input  wire logic        CAPT_ACK_I,
  output var  logic        OVF_IRQ_O,
  output var  logic        CAPT_IRQ_O,
  output var  logic        TIMER_TOP_O,
  output var  logic        TIMER_BOTTOM_O
);

  tcc_req_type   req_reg;
  logic          pend_reg;
  logic [7:0]    ctrl_a_reg;
  logic [7:0]    ctrl_b_reg;
  logic          cmp_sel_reg;
  logic [1:0]    irq_en_reg;
  logic          ovf_flag_reg;
  logic          cap_flag_reg;
  logic [7:0]    temp_reg;
  logic [15:0]   count_reg;
  logic [15:0]   count_next;
  logic [15:0]   cap_reg;
  tcc_slope_type dir_reg;
  tcc_slope_type dir_next;
  logic [9:0]    pre_reg;
  logic [1:0]    ext_sync_reg;
  logic          ext_prev_reg;
  logic          tick;
  logic          ovf_set;
  logic          cap_evt;
  tcc_mode_type  md;
  logic [3:0]    wgm;
  logic [2:0]    clk_sel;
  logic [7:0]    wbyte;
  logic          wr;
  logic          rd;
  logic          wr_cnt_lo;
  logic          rd_cnt_lo;
  logic          wr_cap_lo;
  logic          rd_cap_lo;
  logic [31:0]   rd_data;

  assign wgm     = {ctrl_b_reg[`TCC_B_WGM_LSB+:2], ctrl_a_reg[`TCC_A_WGM_LSB+:2]};
  assign clk_sel = ctrl_b_reg[`TCC_B_CS_LSB+:3];
  assign wbyte   = HWDATA_I[7:0];

  // bus slave: one wait state so writes use hwdata and reads
  // see the effect of any write just before them
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pend_reg    <= 1'b0;
      req_reg     <= '0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HRESP_O <= 1'b0;
      if (pend_reg) begin
        pend_reg    <= 1'b0;
        HREADYOUT_O <= 1'b1;
      end else if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
        pend_reg    <= 1'b1;
        HREADYOUT_O <= 1'b0;
        req_reg     <= '{addr: HADDR_I[7:0], write: HWRITE_I};
      end
    end
  end

  assign wr        = pend_reg & req_reg.write;
  assign rd        = pend_reg & ~req_reg.write;
  assign wr_cnt_lo = wr && req_reg.addr == `TCC_OFS_CNT_LO;
  assign rd_cnt_lo = rd && req_reg.addr == `TCC_OFS_CNT_LO;
  assign wr_cap_lo = wr && req_reg.addr == `TCC_OFS_CAP_LO && md.icr_top;
  assign rd_cap_lo = rd && req_reg.addr == `TCC_OFS_CAP_LO;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_a_reg  <= `TCC_CTRL_RST;
      ctrl_b_reg  <= `TCC_CTRL_RST;
      cmp_sel_reg <= 1'b0;
      irq_en_reg  <= '0;
    end else if (wr) begin
      case (req_reg.addr)
        `TCC_OFS_CTRL_A: ctrl_a_reg  <= wbyte;
        `TCC_OFS_CTRL_B: ctrl_b_reg  <= wbyte;
        `TCC_OFS_CMP_CS: cmp_sel_reg <= wbyte[`TCC_CMP_CAPSEL];
        `TCC_OFS_IRQ_EN: irq_en_reg  <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  // one holding byte serves every 16-bit register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      temp_reg <= `TCC_BYTE_RST;
    end else if (rd_cnt_lo) begin
      temp_reg <= count_reg[15:8];
    end else if (rd_cap_lo) begin
      temp_reg <= cap_reg[15:8];
    end else if (wr && (req_reg.addr == `TCC_OFS_CNT_HI ||
                        req_reg.addr == `TCC_OFS_CAP_HI)) begin
      temp_reg <= wbyte;
    end
  end

  always_comb begin
    rd_data = '0;
    case (req_reg.addr)
      `TCC_OFS_CTRL_A: rd_data[7:0] = ctrl_a_reg;
      `TCC_OFS_CTRL_B: rd_data[7:0] = ctrl_b_reg;
      `TCC_OFS_CNT_LO: rd_data[7:0] = count_reg[7:0];
      `TCC_OFS_CNT_HI: rd_data[7:0] = temp_reg;
      `TCC_OFS_CAP_LO: rd_data[7:0] = cap_reg[7:0];
      `TCC_OFS_CAP_HI: rd_data[7:0] = temp_reg;
      `TCC_OFS_FLAGS: begin
        rd_data[`TCC_FLAG_OVF] = ovf_flag_reg;
        rd_data[`TCC_FLAG_CAP] = cap_flag_reg;
      end
      `TCC_OFS_IRQ_EN: rd_data[1:0] = irq_en_reg;
      `TCC_OFS_CMP_CS: rd_data[`TCC_CMP_CAPSEL] = cmp_sel_reg;
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HRDATA_O <= '0;
    end else if (rd) begin
      HRDATA_O <= rd_data;
    end
  end

  // compare units are absent, so compare-top modes run to MAX
  always_comb begin
    md = '{top: `TCC_MAX, dual: 1'b0, fast: 1'b0, icr_top: 1'b0};
    case (wgm)
      `TCC_WGM_PC8:     md = '{`TCC_TOP8, 1'b1, 1'b0, 1'b0};
      `TCC_WGM_PC9:     md = '{`TCC_TOP9, 1'b1, 1'b0, 1'b0};
      `TCC_WGM_PC10:    md = '{`TCC_TOP10, 1'b1, 1'b0, 1'b0};
      `TCC_WGM_FAST8:   md = '{`TCC_TOP8, 1'b0, 1'b1, 1'b0};
      `TCC_WGM_FAST9:   md = '{`TCC_TOP9, 1'b0, 1'b1, 1'b0};
      `TCC_WGM_FAST10:  md = '{`TCC_TOP10, 1'b0, 1'b1, 1'b0};
      `TCC_WGM_PFC_ICR,
      `TCC_WGM_PC_ICR:  md = '{cap_reg, 1'b1, 1'b0, 1'b1};
      `TCC_WGM_PFC_OCR,
      `TCC_WGM_PC_OCR:  md = '{`TCC_MAX, 1'b1, 1'b0, 1'b0};
      `TCC_WGM_CTC_ICR: md = '{cap_reg, 1'b0, 1'b0, 1'b1};
      `TCC_WGM_FST_ICR: md = '{cap_reg, 1'b0, 1'b1, 1'b1};
      `TCC_WGM_FST_OCR: md = '{`TCC_MAX, 1'b0, 1'b1, 1'b0};
      default:          md = '{`TCC_MAX, 1'b0, 1'b0, 1'b0};
    endcase
  end

  // free-running prescaler; not reset by mode or select changes
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 10'h001;
    end
  end

  // count pin is asynchronous: two flops before any logic
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ext_sync_reg <= '0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], EXT_COUNT_PIN_I};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  always_comb begin
    case (clk_sel)
      `TCC_CS_DIV1:     tick = 1'b1;
      `TCC_CS_DIV8:     tick = (pre_reg & `TCC_PRE_M8) == `TCC_PRE_M8;
      `TCC_CS_DIV64:    tick = (pre_reg & `TCC_PRE_M64) == `TCC_PRE_M64;
      `TCC_CS_DIV256:   tick = (pre_reg & `TCC_PRE_M256) == `TCC_PRE_M256;
      `TCC_CS_DIV1024:  tick = pre_reg == `TCC_PRE_M1024;
      `TCC_CS_EXT_FALL: tick = ext_prev_reg & ~ext_sync_reg[1];
      `TCC_CS_EXT_RISE: tick = ~ext_prev_reg & ext_sync_reg[1];
      default:          tick = 1'b0;
    endcase
  end

  // dual slope turns at TOP and BOTTOM; single slope clears after TOP
  always_comb begin
    count_next = count_reg;
    dir_next   = dir_reg;
    if (md.dual) begin
      if (dir_reg == SLOPE_UP && count_reg == md.top) begin
        dir_next   = SLOPE_DOWN;
        count_next = count_reg - 16'h0001;
      end else if (dir_reg == SLOPE_DOWN && count_reg == `TCC_BOTTOM) begin
        dir_next   = SLOPE_UP;
        count_next = count_reg + 16'h0001;
      end else if (dir_reg == SLOPE_DOWN) begin
        count_next = count_reg - 16'h0001;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end else begin
      dir_next = SLOPE_UP;
      if (count_reg == md.top) begin
        count_next = `TCC_BOTTOM;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      count_reg <= `TCC_CNT_RST;
      dir_reg   <= SLOPE_UP;
    end else if (wr_cnt_lo) begin
      count_reg <= {temp_reg, wbyte};
    end else if (tick) begin
      count_reg <= count_next;
      dir_reg   <= dir_next;
    end
  end

  // a cpu write in the same cycle suppresses the overflow as well
  always_comb begin
    if (!tick || wr_cnt_lo) begin
      ovf_set = 1'b0;
    end else if (md.dual) begin
      ovf_set = dir_reg == SLOPE_DOWN && count_reg == `TCC_BOTTOM;
    end else if (md.fast) begin
      ovf_set = count_reg == md.top;
    end else begin
      ovf_set = count_reg == `TCC_MAX;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TIMER_TOP_O    <= 1'b0;
      TIMER_BOTTOM_O <= 1'b0;
    end else begin
      TIMER_TOP_O    <= count_reg == md.top;
      TIMER_BOTTOM_O <= count_reg == `TCC_BOTTOM;
    end
  end

  // capture pin is the pad level, so port-driven edges are seen too
  tcc_capture u_capture (
    .clk_i      (CLK_I),
    .rst_i      (RST_I),
    .pin_i      (CAPTURE_PIN_I),
    .cmp_i      (COMPARATOR_OUTPUT_I),
    .cmp_sel_i  (cmp_sel_reg),
    .nc_en_i    (ctrl_b_reg[`TCC_B_NC_BIT]),
    .edge_sel_i (ctrl_b_reg[`TCC_B_CES_BIT]),
    .enable_i   (~md.icr_top),
    .event_o    (cap_evt)
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cap_reg <= `TCC_CNT_RST;
    end else if (wr_cap_lo) begin
      cap_reg <= {temp_reg, wbyte};
    end else if (cap_evt) begin
      cap_reg <= count_reg;
    end
  end

  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ovf_flag_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
    end else begin
      if (ovf_set) begin
        ovf_flag_reg <= 1'b1;
      end else if (OVF_ACK_I || (wr && req_reg.addr == `TCC_OFS_FLAGS &&
                                 wbyte[`TCC_FLAG_OVF])) begin
        ovf_flag_reg <= 1'b0;
      end
      if (cap_evt && !wr_cap_lo) begin
        cap_flag_reg <= 1'b1;
      end else if (CAPT_ACK_I || (wr && req_reg.addr == `TCC_OFS_FLAGS &&
                                  wbyte[`TCC_FLAG_CAP])) begin
        cap_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      OVF_IRQ_O  <= 1'b0;
      CAPT_IRQ_O <= 1'b0;
    end else begin
      OVF_IRQ_O  <= ovf_flag_reg & irq_en_reg[`TCC_FLAG_OVF];
      CAPT_IRQ_O <= cap_flag_reg & irq_en_reg[`TCC_FLAG_CAP];
    end
  end

endmodule
`default_nettype wire

// >>> tcc_timer16_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_monitor (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        HSEL_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        OVF_ACK_I,
  input wire logic        CAPT_ACK_I,
  input wire logic        OVF_IRQ_O,
  input wire logic        CAPT_IRQ_O,
  input wire logic        TIMER_TOP_O,
  input wire logic        TIMER_BOTTOM_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire taken = HSEL_I && HTRANS_I[1] && HREADY_I && HREADYOUT_O;

  a_resp_okay: assert property (HRESP_O == 1'b0)
    else $error("bus response not okay");
  a_wait_one: assert property (taken |=> !HREADYOUT_O ##1 HREADYOUT_O)
    else $error("wait state not exactly one cycle");
  a_wait_cause: assert property (!HREADYOUT_O |-> $past(taken))
    else $error("wait state without a transfer");
  a_upper_zero: assert property (HRDATA_O[31:8] == 24'h0)
    else $error("read data above the byte lane");
  a_rdata_hold: assert property (!$stable(HRDATA_O) |-> !$past(HREADYOUT_O))
    else $error("read data changed outside a data phase");
  a_bottom_boot: assert property ($past(RST_I) && !RST_I |=>
    TIMER_BOTTOM_O && !TIMER_TOP_O)
    else $error("bottom not flagged after reset");
  a_ovf_clear: assert property (OVF_ACK_I |-> ##2 !OVF_IRQ_O)
    else $error("overflow request kept after service");
  a_capt_clear: assert property (CAPT_ACK_I |-> ##2 !CAPT_IRQ_O)
    else $error("capture request kept after service");

  c_taken: cover property (taken);
  c_capt: cover property ($rose(CAPT_IRQ_O));
  c_ovf: cover property ($rose(OVF_IRQ_O));
  c_top: cover property ($rose(TIMER_TOP_O));
endmodule
bind tcc_timer16 tcc_timer16_monitor tcc_timer16_monitor_inst (
  .CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
  .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .OVF_ACK_I(OVF_ACK_I), .CAPT_ACK_I(CAPT_ACK_I),
  .OVF_IRQ_O(OVF_IRQ_O), .CAPT_IRQ_O(CAPT_IRQ_O),
  .TIMER_TOP_O(TIMER_TOP_O), .TIMER_BOTTOM_O(TIMER_BOTTOM_O));
`default_nettype wire

// >>> tcc_timer16_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"
module tcc_timer16_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel, hwrite, hready, hresp, rdone;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        ext_pin = 1'b0;
  logic        cap_pin = 1'b0;
  logic        cmp_out = 1'b0;
  logic        ovf_ack = 1'b0;
  logic        capt_ack = 1'b0;
  logic        ovf_irq, capt_irq, top, bottom, e, nc, sel;
  logic [7:0]  rdata;
  logic [7:0]  exp_q[$];
  logic [15:0] v;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #5 clk = ~clk;

  tcc_timer16 tcc_timer16_inst (
    .CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp),
    .EXT_COUNT_PIN_I(ext_pin), .CAPTURE_PIN_I(cap_pin),
    .COMPARATOR_OUTPUT_I(cmp_out), .OVF_ACK_I(ovf_ack),
    .CAPT_ACK_I(capt_ack), .OVF_IRQ_O(ovf_irq), .CAPT_IRQ_O(capt_irq),
    .TIMER_TOP_O(top), .TIMER_BOTTOM_O(bottom));

  tcc_cpu_model tcc_cpu_model_inst (
    .clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata), .rdata_o(rdata),
    .rdone_o(rdone));

  task automatic summarize;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] x);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error at %0t: read %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk_pin(input logic g, input logic x);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error at %0t: output %b expected %b", $time, g, x);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tcc_cpu_model_inst.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    tcc_cpu_model_inst.xfer(1'b0, a, 8'h00);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] x);
    exp_q.push_back(x[7:0]);
    exp_q.push_back(x[15:8]);
    tcc_cpu_model_inst.get16(a);
  endtask
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    tcc_cpu_model_inst.put16(a, d);
  endtask
  task automatic drive(input logic s, input logic l);
    @(posedge clk);
    if (s) cmp_out <= l;
    else cap_pin <= l;
  endtask
  task automatic await(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) @(posedge clk);
  endtask

  // reads complete in order, so the oldest note is the one due
  always @(rdone)
    if (exp_q.size() > 0) chk_rd(rdata, exp_q.pop_front());

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    v = 16'($urandom(32'heace));
    tick(6);
    rst <= 1'b0;
    rd(`TCC_OFS_CTRL_B, 8'h00);
    rd16(`TCC_OFS_CNT_LO, 16'h0000);
    v = 16'($urandom);
    put(`TCC_OFS_CNT_LO, v);
    tick(20);
    rd16(`TCC_OFS_CNT_LO, v);
    rd(`TCC_OFS_CNT_HI, v[15:8]);
    put(`TCC_OFS_CAP_LO, ~v);
    rd16(`TCC_OFS_CAP_LO, 16'h0000);
    wr(`TCC_OFS_CTRL_B, 8'h58);
    wr(`TCC_OFS_CNT_HI, v[15:8]);
    wr(`TCC_OFS_CNT_LO, v[7:0]);
    wr(`TCC_OFS_CAP_LO, ~v[7:0]);
    rd16(`TCC_OFS_CAP_LO, {v[15:8], ~v[7:0]});
    rd16(`TCC_OFS_CNT_LO, v);
    wr(`TCC_OFS_IRQ_EN, 8'h03);
    drive(1'b0, 1'b1);
    tick(20);
    chk_pin(capt_irq, 1'b0);
    for (int k = 0; k < 8; k++) begin
      {nc, sel, e} = 3'(k);
      cap_pin <= ~e;
      cmp_out <= ~e;
      wr(`TCC_OFS_CMP_CS, {5'h0, sel, 2'h0});
      wr(`TCC_OFS_CTRL_B, {nc, e, 6'h00});
      tick(12);
      wr(`TCC_OFS_FLAGS, 8'h02);
      v = 16'($urandom);
      put(`TCC_OFS_CNT_LO, v);
      if (nc) begin
        drive(sel, e);
        tick(1);
        drive(sel, ~e);
        tick(12);
        chk_pin(capt_irq, 1'b0);
      end
      drive(sel, e);
      tick(7);
      chk_pin(capt_irq, ~nc);
      tick(3);
      chk_pin(capt_irq, 1'b1);
      tick(10);
      chk_pin(capt_irq, 1'b1);
      rd16(`TCC_OFS_CAP_LO, v);
      rd(`TCC_OFS_FLAGS, 8'h02);
      if (e) begin
        @(posedge clk) capt_ack <= 1'b1;
        @(posedge clk) capt_ack <= 1'b0;
      end else begin
        wr(`TCC_OFS_FLAGS, 8'h02);
      end
      drive(sel, ~e);
      tick(20);
      chk_pin(capt_irq, 1'b0);
    end
    // phase-correct 8-bit: up to 0xff, then down to zero
    wr(`TCC_OFS_CTRL_B, 8'h00);
    wr(`TCC_OFS_CTRL_A, 8'h01);
    wr(`TCC_OFS_FLAGS, 8'h02);
    put(`TCC_OFS_CNT_LO, 16'h00f0);
    wr(`TCC_OFS_CTRL_B, 8'h01);
    await(top, 100);
    chk_pin(top, 1'b1);
    await(bottom, 300);
    chk_pin(bottom, 1'b1);
    await(ovf_irq, 8);
    chk_pin(ovf_irq, 1'b1);
    @(posedge clk) ovf_ack <= 1'b1;
    @(posedge clk) ovf_ack <= 1'b0;
    wr(`TCC_OFS_CTRL_B, 8'h00);
    rd(`TCC_OFS_FLAGS, 8'h00);
    // count pin: three edges of the selected polarity, then stop
    wr(`TCC_OFS_CTRL_A, 8'h00);
    for (int c = 0; c < 2; c++) begin
      v = 16'($urandom);
      put(`TCC_OFS_CNT_LO, v);
      wr(`TCC_OFS_CTRL_B, {5'h0, c ? `TCC_CS_EXT_RISE : `TCC_CS_EXT_FALL});
      repeat (3) begin
        @(posedge clk) ext_pin <= 1'b1;
        tick(3);
        ext_pin <= 1'b0;
        tick(3);
      end
      wr(`TCC_OFS_CTRL_B, 8'h00);
      rd16(`TCC_OFS_CNT_LO, v + 16'h0003);
    end
    tick(5);
    if (exp_q.size() > 0) n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
